// ---- tla_limit_alert.sv ----
// Limit registers, alarm comparison, status flags and alert pin control
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - High limit bytes read at 05h/07h, written at 0Bh/0Dh; fraction at 13h.
// - High limit bytes reset to 46h; remote high fraction resets to zero.
// - Low limit bytes read at 06h/08h, written at 0Ch/0Eh; fraction at 14h.
// - Low limit bytes and remote low fraction reset to zero.
// - Critical limits at 20h (local) and 19h (remote), reset to 55h.
// - Critical hysteresis at 21h, bits 4..0 only, resets to 0Ah.
// - Remote offset integer at 11h and fraction at 12h, both reset zero.
// - Alert mode at BFh; bit 0 high is comparator, upper bits read zero.
// - Address FEh reads a fixed maker identification byte.
// - Address FFh reads the die revision byte.
// - Write to 0Fh in standby starts one conversion; data ignored.
// - One-shot location stores nothing and always reads FFh.
// - Alert pin is open-drain, active low, only ever pulls low.
// - Each result is compared with high, critical, low limits; flags set.
// - Unmasked, any flag except busy and diode open pulls alert low.
// - Comparator mode releases alert once the out-of-limit condition ends.
// - Interrupt mode status read sets alert mask if any alarm flag set.
// - Status flags clear only on a host status read.
// - Interrupt mode status read clears flags, releases alert, sets mask if an alarm flag was set.
// - While masked, alert stays inactive despite new out-of-limit results.
// - Setup byte read 03h, written 09h; bit 7 alert mask, resets low.
// - Status byte read-only at 02h with busy, alarm and open flags.
module tla_limit_alert (
   input  wire logic              clk,            // System clock, 25 MHz
   input  wire logic              rst,            // Synchronous reset, high
   input  wire tla_pkg::tla_req_t req,            // Register access request
   output logic [7:0]             reg_rdata,      // Read data, registered
   input  wire tla_pkg::tla_conv_t conv,          // Conversion result
   output logic                   one_shot_start, // Start one conversion
   output logic                   alert_out,      // Alert pin output level
   output logic                   alert_oe        // Alert pin pull-low enable
);

   logic [7:0]  loc_high_reg;
   logic [7:0]  loc_low_reg;
   logic [7:0]  rem_high_reg;
   logic [7:0]  rem_low_reg;
   logic [7:0]  rem_high_frac_reg;
   logic [7:0]  rem_low_frac_reg;
   logic [7:0]  loc_crit_reg;
   logic [7:0]  rem_crit_reg;
   logic [7:0]  hyst_reg;
   logic [7:0]  offset_int_reg;
   logic [7:0]  offset_frac_reg;
   logic [7:0]  mode_reg;
   logic [7:0]  setup_reg;
   logic [7:0]  flags_reg;
   logic [7:0]  cond_reg;
   logic [7:0]  rdata_reg;
   logic        one_shot_reg;
   logic        alert_reg;
   logic        alert_next;
   logic        status_rd;
   logic        int_mode;
   logic [10:0] rem_adj;
   logic [7:0]  new_bits;

   function automatic logic wr_at(input tla_pkg::tla_req_t r,
                                  input logic [7:0] a);
      wr_at = r.wr && (r.addr == a);
   endfunction : wr_at

   assign status_rd = req.rd && (req.addr == tla_pkg::ADDR_STATUS);
   assign int_mode  = !mode_reg[tla_pkg::MODE_COMPARATOR];

   ////////////////////////////////////////////////////////////////////////////
   // Limit, offset and hysteresis registers

   always_ff @(posedge clk) begin
      if (rst) begin
         loc_high_reg      <= tla_pkg::RST_HIGH_LIMIT;
         rem_high_reg      <= tla_pkg::RST_HIGH_LIMIT;
         rem_high_frac_reg <= tla_pkg::RST_ZERO;
         loc_low_reg       <= tla_pkg::RST_LOW_LIMIT;
         rem_low_reg       <= tla_pkg::RST_LOW_LIMIT;
         rem_low_frac_reg  <= tla_pkg::RST_ZERO;
         loc_crit_reg      <= tla_pkg::RST_CRIT_LIMIT;
         rem_crit_reg      <= tla_pkg::RST_CRIT_LIMIT;
         hyst_reg          <= tla_pkg::RST_CRIT_HYST;
         offset_int_reg    <= tla_pkg::RST_ZERO;
         offset_frac_reg   <= tla_pkg::RST_ZERO;
      end else begin
         if (wr_at(req, tla_pkg::ADDR_LOC_HIGH_WR)) begin
            loc_high_reg <= req.wdata;
         end
         if (wr_at(req, tla_pkg::ADDR_REM_HIGH_WR)) begin
            rem_high_reg <= req.wdata;
         end
         if (wr_at(req, tla_pkg::ADDR_REM_HIGH_FRAC)) begin
            rem_high_frac_reg <= req.wdata & tla_pkg::FRAC_MASK;
         end
         if (wr_at(req, tla_pkg::ADDR_LOC_LOW_WR)) begin
            loc_low_reg <= req.wdata;
         end
         if (wr_at(req, tla_pkg::ADDR_REM_LOW_WR)) begin
            rem_low_reg <= req.wdata;
         end
         if (wr_at(req, tla_pkg::ADDR_REM_LOW_FRAC)) begin
            rem_low_frac_reg <= req.wdata & tla_pkg::FRAC_MASK;
         end
         if (wr_at(req, tla_pkg::ADDR_LOC_CRIT)) begin
            loc_crit_reg <= req.wdata;
         end
         if (wr_at(req, tla_pkg::ADDR_REM_CRIT)) begin
            rem_crit_reg <= req.wdata;
         end
         if (wr_at(req, tla_pkg::ADDR_CRIT_HYST)) begin
            hyst_reg <= req.wdata & tla_pkg::HYST_MASK;
         end
         if (wr_at(req, tla_pkg::ADDR_OFFSET_INT)) begin
            offset_int_reg <= req.wdata;
         end
         if (wr_at(req, tla_pkg::ADDR_OFFSET_FRAC)) begin
            offset_frac_reg <= req.wdata & tla_pkg::FRAC_MASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alert mode and setup byte

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= tla_pkg::RST_ZERO;
      end else if (wr_at(req, tla_pkg::ADDR_ALERT_MODE)) begin
         mode_reg <= req.wdata & tla_pkg::MODE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         setup_reg <= tla_pkg::RST_ZERO;
      end else if (status_rd && int_mode &&
                   |(flags_reg & tla_pkg::ALARM_MASK)) begin
         setup_reg[tla_pkg::SETUP_ALERT_MASK] <= 1'b1;
      end else if (wr_at(req, tla_pkg::ADDR_SETUP_WR)) begin
         setup_reg <= req.wdata & tla_pkg::SETUP_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Comparison of each result against the limits

   // Offset wraps in two's complement; no saturation
   assign rem_adj = conv.remote_temp +
                    {offset_int_reg, offset_frac_reg[7:5]};

   always_comb begin
      new_bits = tla_pkg::NO_FLAGS;
      new_bits[tla_pkg::ST_LOC_HIGH] =
         $signed(conv.local_temp) > $signed(loc_high_reg);
      new_bits[tla_pkg::ST_LOC_LOW] =
         $signed(conv.local_temp) < $signed(loc_low_reg);
      new_bits[tla_pkg::ST_LOC_CRIT] =
         $signed(conv.local_temp) > $signed(loc_crit_reg);
      new_bits[tla_pkg::ST_REM_HIGH] = $signed(rem_adj) >
         $signed({rem_high_reg, rem_high_frac_reg[7:5]});
      new_bits[tla_pkg::ST_REM_LOW] = $signed(rem_adj) <
         $signed({rem_low_reg, rem_low_frac_reg[7:5]});
      new_bits[tla_pkg::ST_REM_CRIT] = $signed(rem_adj) >
         $signed({rem_crit_reg, 3'b000});
      new_bits[tla_pkg::ST_DIODE_OPEN] = conv.diode_open;
   end

   // Live condition of the latest result, for comparator mode
   always_ff @(posedge clk) begin
      if (rst) begin
         cond_reg <= tla_pkg::NO_FLAGS;
      end else if (conv.done) begin
         cond_reg <= new_bits & tla_pkg::ALARM_MASK;
      end
   end

   // Sticky flags; a new result in the read cycle survives the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_reg <= tla_pkg::NO_FLAGS;
      end else begin
         flags_reg <= (status_rd ? tla_pkg::NO_FLAGS : flags_reg) |
                      (conv.done ? new_bits : tla_pkg::NO_FLAGS);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alert pin

   always_comb begin
      if (setup_reg[tla_pkg::SETUP_ALERT_MASK]) begin
         alert_next = 1'b0;
      end else if (!int_mode) begin
         alert_next = |cond_reg;
      end else begin
         alert_next = |(flags_reg & tla_pkg::ALARM_MASK);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         alert_reg <= 1'b0;
      end else begin
         alert_reg <= alert_next;
      end
   end

   assign alert_out = 1'b0;
   assign alert_oe  = alert_reg;

   ////////////////////////////////////////////////////////////////////////////
   // One-shot trigger

   always_ff @(posedge clk) begin
      if (rst) begin
         one_shot_reg <= 1'b0;
      end else begin
         one_shot_reg <= wr_at(req, tla_pkg::ADDR_ONE_SHOT) &&
                         setup_reg[tla_pkg::SETUP_STANDBY];
      end
   end

   assign one_shot_start = one_shot_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= tla_pkg::RST_ZERO;
      end else if (req.rd) begin
         if (req.addr == tla_pkg::ADDR_STATUS) begin
            rdata_reg <= {conv.busy, flags_reg[6:0]};
         end else if (req.addr == tla_pkg::ADDR_SETUP_RD) begin
            rdata_reg <= setup_reg;
         end else if (req.addr == tla_pkg::ADDR_LOC_HIGH_RD) begin
            rdata_reg <= loc_high_reg;
         end else if (req.addr == tla_pkg::ADDR_REM_HIGH_RD) begin
            rdata_reg <= rem_high_reg;
         end else if (req.addr == tla_pkg::ADDR_REM_HIGH_FRAC) begin
            rdata_reg <= rem_high_frac_reg;
         end else if (req.addr == tla_pkg::ADDR_LOC_LOW_RD) begin
            rdata_reg <= loc_low_reg;
         end else if (req.addr == tla_pkg::ADDR_REM_LOW_RD) begin
            rdata_reg <= rem_low_reg;
         end else if (req.addr == tla_pkg::ADDR_REM_LOW_FRAC) begin
            rdata_reg <= rem_low_frac_reg;
         end else if (req.addr == tla_pkg::ADDR_LOC_CRIT) begin
            rdata_reg <= loc_crit_reg;
         end else if (req.addr == tla_pkg::ADDR_REM_CRIT) begin
            rdata_reg <= rem_crit_reg;
         end else if (req.addr == tla_pkg::ADDR_CRIT_HYST) begin
            rdata_reg <= hyst_reg;
         end else if (req.addr == tla_pkg::ADDR_OFFSET_INT) begin
            rdata_reg <= offset_int_reg;
         end else if (req.addr == tla_pkg::ADDR_OFFSET_FRAC) begin
            rdata_reg <= offset_frac_reg;
         end else if (req.addr == tla_pkg::ADDR_ALERT_MODE) begin
            rdata_reg <= mode_reg;
         end else if (req.addr == tla_pkg::ADDR_MAKER_ID) begin
            rdata_reg <= tla_pkg::MAKER_ID_VALUE;
         end else if (req.addr == tla_pkg::ADDR_DIE_REV) begin
            rdata_reg <= tla_pkg::DIE_REV_VALUE;
         end else if (req.addr == tla_pkg::ADDR_ONE_SHOT) begin
            rdata_reg <= tla_pkg::ONE_SHOT_READ;
         end else begin
            rdata_reg <= tla_pkg::UNMAPPED_READ;
         end
      end
   end

   assign reg_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence seq_status_read;
      status_rd && !conv.done;
   endsequence

   sequence seq_int_alarm_read;
      status_rd && int_mode && |(flags_reg & tla_pkg::ALARM_MASK);
   endsequence

   a_local_high_flag: assert property (
      conv.done && ($signed(conv.local_temp) > $signed(loc_high_reg))
      |=> flags_reg[tla_pkg::ST_LOC_HIGH])
      else $error("local high flag not set");

   a_status_read_clear: assert property (
      seq_status_read |=> flags_reg == tla_pkg::NO_FLAGS)
      else $error("flags not cleared by status read");

   a_flags_stay_set: assert property (
      !status_rd |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
      else $error("flag cleared without status read");

   a_read_sets_mask: assert property (
      seq_int_alarm_read ##1 1 |-> setup_reg[tla_pkg::SETUP_ALERT_MASK])
      else $error("mask not set by status read");

   a_read_releases: assert property (
      seq_int_alarm_read |=> ##1 !alert_oe)
      else $error("alert not released after status read");

   a_mask_silences: assert property (
      setup_reg[tla_pkg::SETUP_ALERT_MASK] |=> !alert_oe)
      else $error("alert active while masked");

   a_int_alert_low: assert property (
      int_mode && !setup_reg[tla_pkg::SETUP_ALERT_MASK] &&
      |(flags_reg & tla_pkg::ALARM_MASK) |=> alert_oe)
      else $error("alert not driven for set flag");

   a_cmp_release: assert property (
      !int_mode && (cond_reg == tla_pkg::NO_FLAGS) |=> !alert_oe)
      else $error("comparator alert not released");

   a_pin_pull_low: assert property (
      alert_out == 1'b0)
      else $error("alert pin driven high");

   a_one_shot_pulse: assert property (
      wr_at(req, tla_pkg::ADDR_ONE_SHOT) &&
      setup_reg[tla_pkg::SETUP_STANDBY] |=> one_shot_start ##1
      !one_shot_start || $past(req.wr))
      else $error("one-shot start not pulsed");

   a_one_shot_read: assert property (
      req.rd && (req.addr == tla_pkg::ADDR_ONE_SHOT)
      |=> reg_rdata == tla_pkg::ONE_SHOT_READ)
      else $error("one-shot read not all ones");

   a_mode_upper_zero: assert property (
      req.rd && (req.addr == tla_pkg::ADDR_ALERT_MODE)
      |=> reg_rdata[7:1] == 7'h00)
      else $error("alert mode upper bits not zero");

   a_local_low_flag: assert property (
      conv.done && ($signed(conv.local_temp) < $signed(loc_low_reg))
      |=> flags_reg[tla_pkg::ST_LOC_LOW])
      else $error("local low flag not set");

   a_cmp_alert_low: assert property (
      !int_mode && !setup_reg[tla_pkg::SETUP_ALERT_MASK] &&
      (cond_reg != tla_pkg::NO_FLAGS) |=> alert_oe)
      else $error("comparator alert not driven");

   a_status_read_data: assert property (
      status_rd |=> (reg_rdata & tla_pkg::ALARM_MASK) ==
      ($past(flags_reg) & tla_pkg::ALARM_MASK))
      else $error("status read data wrong");

   a_status_busy_bit: assert property (
      status_rd |=> reg_rdata[tla_pkg::ST_BUSY] == $past(conv.busy))
      else $error("status busy bit wrong");

   a_one_shot_idle: assert property (
      wr_at(req, tla_pkg::ADDR_ONE_SHOT) &&
      !setup_reg[tla_pkg::SETUP_STANDBY] |=> !one_shot_start)
      else $error("one-shot start outside standby");

   a_setup_read_back: assert property (
      req.rd && (req.addr == tla_pkg::ADDR_SETUP_RD)
      |=> reg_rdata == $past(setup_reg))
      else $error("setup byte read back wrong");

endmodule : tla_limit_alert

// ---- tla_pkg.sv ----
// Package: register map, reset values and carriers of the limit/alert logic
package tla_pkg;

   // Register addresses (command bytes)
   localparam logic [7:0] ADDR_STATUS        = 8'h02;
   localparam logic [7:0] ADDR_SETUP_RD      = 8'h03;
   localparam logic [7:0] ADDR_LOC_HIGH_RD   = 8'h05;
   localparam logic [7:0] ADDR_LOC_LOW_RD    = 8'h06;
   localparam logic [7:0] ADDR_REM_HIGH_RD   = 8'h07;
   localparam logic [7:0] ADDR_REM_LOW_RD    = 8'h08;
   localparam logic [7:0] ADDR_SETUP_WR      = 8'h09;
   localparam logic [7:0] ADDR_LOC_HIGH_WR   = 8'h0b;
   localparam logic [7:0] ADDR_LOC_LOW_WR    = 8'h0c;
   localparam logic [7:0] ADDR_REM_HIGH_WR   = 8'h0d;
   localparam logic [7:0] ADDR_REM_LOW_WR    = 8'h0e;
   localparam logic [7:0] ADDR_ONE_SHOT      = 8'h0f;
   localparam logic [7:0] ADDR_OFFSET_INT    = 8'h11;
   localparam logic [7:0] ADDR_OFFSET_FRAC   = 8'h12;
   localparam logic [7:0] ADDR_REM_HIGH_FRAC = 8'h13;
   localparam logic [7:0] ADDR_REM_LOW_FRAC  = 8'h14;
   localparam logic [7:0] ADDR_REM_CRIT      = 8'h19;
   localparam logic [7:0] ADDR_LOC_CRIT      = 8'h20;
   localparam logic [7:0] ADDR_CRIT_HYST     = 8'h21;
   localparam logic [7:0] ADDR_ALERT_MODE    = 8'hbf;
   localparam logic [7:0] ADDR_MAKER_ID      = 8'hfe;
   localparam logic [7:0] ADDR_DIE_REV       = 8'hff;

   // Reset values
   localparam logic [7:0] RST_HIGH_LIMIT = 8'h46;
   localparam logic [7:0] RST_LOW_LIMIT  = 8'h00;
   localparam logic [7:0] RST_CRIT_LIMIT = 8'h55;
   localparam logic [7:0] RST_CRIT_HYST  = 8'h0a;
   localparam logic [7:0] RST_ZERO       = 8'h00;

   // Identification bytes; values are arbitrary
   localparam logic [7:0] MAKER_ID_VALUE = 8'h5c;
   localparam logic [7:0] DIE_REV_VALUE  = 8'h01;

   // Fixed read values and field masks
   localparam logic [7:0] ONE_SHOT_READ  = 8'hff;
   localparam logic [7:0] UNMAPPED_READ  = 8'h00;
   localparam logic [7:0] FRAC_MASK      = 8'he0;
   localparam logic [7:0] HYST_MASK      = 8'h1f;
   localparam logic [7:0] MODE_MASK      = 8'h01;
   localparam logic [7:0] SETUP_MASK     = 8'hd5;
   localparam logic [7:0] ALARM_MASK     = 8'h7b;
   localparam logic [7:0] NO_FLAGS       = 8'h00;

   // Bit positions
   localparam int SETUP_ALERT_MASK = 7;
   localparam int SETUP_STANDBY    = 6;
   localparam int MODE_COMPARATOR  = 0;
   localparam int ST_BUSY          = 7;
   localparam int ST_LOC_HIGH      = 6;
   localparam int ST_LOC_LOW       = 5;
   localparam int ST_REM_HIGH      = 4;
   localparam int ST_REM_LOW       = 3;
   localparam int ST_DIODE_OPEN    = 2;
   localparam int ST_REM_CRIT      = 1;
   localparam int ST_LOC_CRIT      = 0;

   // Register access from the serial front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tla_req_t;

   // One conversion result; remote is integer byte plus three fraction bits
   typedef struct packed {
      logic        done;
      logic        busy;
      logic        diode_open;
      logic [7:0]  local_temp;
      logic [10:0] remote_temp;
   } tla_conv_t;

endpackage : tla_pkg

// ---- tla_host_model.sv ----
// Host controller model: register access and alert service routine
`timescale 1ns/1ps

module tla_host_model (
   input  wire logic         clk,       // System clock
   output tla_pkg::tla_req_t req,       // Register request to the block
   input  wire logic [7:0]   reg_rdata, // Read data from the block
   input  wire logic         alert_out, // Pin drive level
   input  wire logic         alert_oe,  // Pin pull-low enable
   output logic              alert_n    // Shared line with pull-up
);

   // Line floats to the pull-up unless pulled low
   assign alert_n = alert_oe ? alert_out : 1'b1;

   initial req = '0;

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req.wr    = 1'b1;
      req.addr  = a;
      req.wdata = d;
      @(negedge clk);
      req.wr    = 1'b0;
      req.addr  = ~a;
      req.wdata = ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      req.rd   = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd   = 1'b0;
      req.addr = ~a;
      d        = reg_rdata;
   endtask : rd

   // Read status, then re-enable the alert
   task automatic service(output logic [7:0] st);
      rd(tla_pkg::ADDR_STATUS, st);
      wr(tla_pkg::ADDR_SETUP_WR, 8'h00);
   endtask : service

endmodule : tla_host_model

// ---- temp_limit_alert_logic_tb.sv ----
// Self-checking testbench of the limit and alert logic
`timescale 1ns/1ps

module temp_limit_alert_logic_tb;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   tla_pkg::tla_conv_t conv = '0;
   tla_pkg::tla_req_t  req;
   logic [7:0]         reg_rdata;
   logic               one_shot_start;
   logic               alert_out;
   logic               alert_oe;
   logic               alert_n;
   int                 n_errors = 0;
   int                 checked = 0;
   logic [7:0]         d;
   // {read addr, expected} after reset
   logic [15:0] rst_tab [19] = '{16'h0200, 16'h0300, 16'h0546, 16'h0600,
      16'h0746, 16'h0800, 16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h1955,
      16'h2055, 16'h210a, 16'hbf00, {8'hfe, tla_pkg::MAKER_ID_VALUE},
      {8'hff, tla_pkg::DIE_REV_VALUE}, 16'h0fff, 16'h0b00, 16'h3000};
   // {write addr, read addr, data, expected}
   logic [31:0] rw_tab [14] = '{32'h0b053232, 32'h0c060a0a,
      32'h0d073232, 32'h0e080a0a, 32'h1313a3a0, 32'h14143f20,
      32'h1212ffe0, 32'h12120000, 32'h19193c3c, 32'h20203c3c,
      32'h2121ff1f, 32'hbfbfff01, 32'h0f0fabff, 32'h05053232};
   // {local, remote int+frac, open, expected status}
   logic [27:0] cv_tab [11] = '{{8'h3d, 11'h0a0, 1'b0, 8'h41},
      {8'h09, 11'h0a0, 1'b0, 8'h20}, {8'h0a, 11'h0a0, 1'b0, 8'h00},
      {8'h14, 11'h195, 1'b0, 8'h00}, {8'h14, 11'h196, 1'b0, 8'h10},
      {8'h14, 11'h051, 1'b0, 8'h00}, {8'h14, 11'h050, 1'b0, 8'h08},
      {8'h14, 11'h1e8, 1'b0, 8'h12}, {8'h14, 11'h0a0, 1'b1, 8'h04},
      {8'h33, 11'h0a0, 1'b0, 8'h40}, {8'h32, 11'h0a0, 1'b0, 8'h00}};

   always #20 clk = ~clk;

   tla_limit_alert dut_u (
      .clk            (clk),
      .rst            (rst),
      .req            (req),
      .reg_rdata      (reg_rdata),
      .conv           (conv),
      .one_shot_start (one_shot_start),
      .alert_out      (alert_out),
      .alert_oe       (alert_oe)
   );

   tla_host_model host_u (
      .clk       (clk),
      .req       (req),
      .reg_rdata (reg_rdata),
      .alert_out (alert_out),
      .alert_oe  (alert_oe),
      .alert_n   (alert_n)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host_u.rd(a, v);
      chk(v, exp);
   endtask : rd_chk

   // One result; alert settles one edge after the result edge
   task automatic convert(input logic [7:0] loc, input logic [10:0] rem,
                          input logic open);
      @(negedge clk);
      conv.done        = 1'b1;
      conv.local_temp  = loc;
      conv.remote_temp = rem;
      conv.diode_open  = open;
      @(negedge clk);
      conv.done        = 1'b0;
      conv.diode_open  = ~open;
      repeat (2) @(negedge clk);
   endtask : convert

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      foreach (rst_tab[i]) rd_chk(rst_tab[i][15:8], rst_tab[i][7:0]);
      foreach (rw_tab[i]) begin
         host_u.wr(rw_tab[i][31:24], rw_tab[i][15:8]);
         rd_chk(rw_tab[i][23:16], rw_tab[i][7:0]);
      end
      host_u.wr(tla_pkg::ADDR_ALERT_MODE, 8'h00);
      // Interrupt mode: assert, status read masks, masked result
      convert(8'h33, 11'h0a0, 1'b0);
      chk({7'h00, alert_n}, 8'h00);
      chk({7'h00, alert_out}, 8'h00);
      rd_chk(tla_pkg::ADDR_STATUS, 8'h40);
      rd_chk(tla_pkg::ADDR_SETUP_RD, 8'h80);
      chk({7'h00, alert_n}, 8'h01);
      rd_chk(tla_pkg::ADDR_STATUS, 8'h00);
      convert(8'h33, 11'h0a0, 1'b0);
      chk({7'h00, alert_n}, 8'h01);
      host_u.wr(tla_pkg::ADDR_SETUP_WR, 8'h00);
      repeat (2) @(negedge clk);
      chk({7'h00, alert_n}, 8'h00);
      // Every flag except busy through the service routine
      foreach (cv_tab[i]) begin
         host_u.service(d);
         convert(cv_tab[i][27:20], cv_tab[i][19:9], cv_tab[i][8]);
         chk({7'h00, alert_n}, {7'h00, ~|(cv_tab[i][7:0] & 8'h7b)});
         rd_chk(tla_pkg::ADDR_STATUS, cv_tab[i][7:0]);
      end
      // Comparator mode follows the latest result
      host_u.service(d);
      host_u.wr(tla_pkg::ADDR_ALERT_MODE, 8'h01);
      convert(8'h14, 11'h1e8, 1'b0);
      chk({7'h00, alert_n}, 8'h00);
      convert(8'h14, 11'h0a0, 1'b0);
      chk({7'h00, alert_n}, 8'h01);
      rd_chk(tla_pkg::ADDR_STATUS, 8'h12);
      // Busy shows live in status and never drives the alert
      conv.busy = 1'b1;
      rd_chk(tla_pkg::ADDR_STATUS, 8'h80);
      chk({7'h00, alert_n}, 8'h01);
      conv.busy = 1'b0;
      // Offset of 40 lifts remote 20 to 60: high only, not critical
      host_u.wr(tla_pkg::ADDR_OFFSET_INT, 8'h28);
      convert(8'h14, 11'h0a0, 1'b0);
      rd_chk(tla_pkg::ADDR_STATUS, 8'h10);
      // One-shot only in standby
      host_u.wr(tla_pkg::ADDR_ONE_SHOT, 8'h5a);
      chk({7'h00, one_shot_start}, 8'h00);
      host_u.wr(tla_pkg::ADDR_SETUP_WR, 8'h40);
      host_u.wr(tla_pkg::ADDR_ONE_SHOT, 8'h00);
      chk({7'h00, one_shot_start}, 8'h01);
      @(negedge clk);
      chk({7'h00, one_shot_start}, 8'h00);
      rd_chk(tla_pkg::ADDR_ONE_SHOT, 8'hff);
      tally_and_finish();
   end

endmodule : temp_limit_alert_logic_tb
